//--- design/tpa_device.sv
// Purpose: phase alignment, centering and block-program control.
// Assumes: tdm clocks and frame pulses synchronous to clock_i.
// Notes:   frame pulses are one-cycle high pulses.
`timescale 1ns/1ps
`default_nettype none
module tpa_device (
	input  wire logic  clock_i,
	input  wire logic  rst_b_i,
	tpa_if.dev         bus,
	input  wire logic  serial_port_clock_i,
	input  wire logic  par_tx_clock_i,
	input  wire logic  serial_frame_in_i,
	input  wire logic  par_rx_frame_in_i,
	output logic       par_tx_frame_out_o,
	output logic       serial_frame_out_o,
	output logic       serial_clock_out_o,
	output logic       fill_we_o,
	output logic       fill_rx_o,
	output logic [11:0] fill_addr_o,
	output logic [3:0] fill_nibble_o
);
	import tpa_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] intf;
		logic [7:0] ctl;
		logic [7:0] tim;
		logic [7:0] gen;
		logic [7:0] alm;
		logic [7:0] rdata;
		logic       rvalid;
		logic       irq;
		logic [7:0] tx_cnt;
		logic [7:0] tx_len;
		logic       tx_lock;
		logic [7:0] rx_cnt;
		logic [7:0] rx_len;
		logic       rx_lock;
		logic [7:0] tx_per;
		logic [7:0] tx_meas;
		logic [7:0] rx_per;
		logic [7:0] rx_meas;
		logic       sclk_inv;
		logic       sclk_prev;
		logic       ptx_prev;
		logic [3:0] ctr_frames;
		tpa_fill_t  fill;
		logic       fill_rx;
		logic [11:0] addr;
		logic       we;
		logic       ptx_frame;
		logic       ser_frame;
		logic       sclk_out;
	} tpa_dev_t;

	tpa_dev_t q, d;

	logic       rx_timed, tx_timed, align_on;
	logic       ser_edge, ptx_edge, fill_edge;
	logic [3:0] window;
	logic [7:0] flags;
	logic [7:0] tx_raw, rx_raw;

	always_comb begin
		rx_timed = q.tim[TPA_TIM_MODE_LO +: 2] == TPA_MODE_RX_TIMED;
		tx_timed = q.tim[TPA_TIM_MODE_LO +: 2] == TPA_MODE_TX_TIMED;
		align_on = tx_timed || (rx_timed && !q.tim[TPA_TIM_INTERNAL_CLOCK_SELECT]);
		ser_edge = serial_port_clock_i && !q.sclk_prev;
		ptx_edge = par_tx_clock_i && !q.ptx_prev;
		// centering narrows the tolerated phase error
		window = q.gen[TPA_GEN_CENTER] ? TPA_WIN_NARROW : TPA_WIN_WIDE;
		tx_raw = q.tx_per - 8'h01;
		rx_raw = q.rx_per - 8'h01;
		flags = 8'h00;
		d = q;
		d.sclk_prev = serial_port_clock_i;
		d.ptx_prev = par_tx_clock_i;
		d.rvalid = 1'b0;
		d.we = 1'b0;
		d.ptx_frame = 1'b0;
		d.ser_frame = 1'b0;

		// ----------------------------------------
		// tx-timed: parallel tx frame follows serial frame
		// ----------------------------------------
		if (ptx_edge) begin
			d.tx_cnt = (q.tx_cnt == q.tx_len) ? 8'h00 : q.tx_cnt + 8'h01;
			if (q.tx_cnt == q.tx_len)
				d.ptx_frame = 1'b1;
			if (q.tx_per != TPA_PHASE_MAX)
				d.tx_per = q.tx_per + 8'h01;
		end
		// length learnt only when two frames agree, so a jump is no period
		if (serial_frame_in_i) begin
			d.tx_per = {7'h00, ptx_edge};
			d.tx_meas = tx_raw;
			if (tx_raw == q.tx_meas)
				d.tx_len = q.tx_meas;
		end
		if (serial_frame_in_i && tx_timed && align_on) begin
			if (!q.tx_lock) begin
				if (q.tx_len != 8'h00) begin
					d.tx_cnt = 8'h00;
					d.tx_lock = 1'b1;
				end
			end else if (q.tx_cnt > 8'(window) &&
				     q.tx_cnt < q.tx_len - 8'(window)) begin
				d.tx_cnt = 8'h00;
				flags[TPA_ALM_TX] = 1'b1;
			end
		end

		// ----------------------------------------
		// rx-timed: serial clock inversion re-phases frame
		// ----------------------------------------
		if (ser_edge) begin
			d.rx_cnt = (q.rx_cnt == q.rx_len) ? 8'h00 : q.rx_cnt + 8'h01;
			if (q.rx_cnt == q.rx_len)
				d.ser_frame = 1'b1;
			if (q.rx_per != TPA_PHASE_MAX)
				d.rx_per = q.rx_per + 8'h01;
		end
		if (par_rx_frame_in_i) begin
			d.rx_per = {7'h00, ser_edge};
			d.rx_meas = rx_raw;
			if (rx_raw == q.rx_meas)
				d.rx_len = q.rx_meas;
		end
		if (par_rx_frame_in_i && rx_timed) begin
			if (q.rx_lock && rx_raw != q.rx_meas)
				flags[TPA_ALM_FRAMING] = 1'b1;
			if (align_on) begin
				if (!q.rx_lock) begin
					if (q.rx_len != 8'h00) begin
						d.sclk_inv = !q.sclk_inv;
						d.rx_cnt = 8'h00;
						d.rx_lock = 1'b1;
					end
				end else if (q.rx_cnt > 8'(window) &&
					     q.rx_cnt < q.rx_len - 8'(window)) begin
					d.sclk_inv = !q.sclk_inv;
					d.rx_cnt = 8'h00;
					flags[TPA_ALM_RX] = 1'b1;
				end
			end
		end
		if (!align_on) begin
			d.tx_lock = 1'b0;
			d.rx_lock = 1'b0;
		end
		d.sclk_out = serial_port_clock_i ^ q.sclk_inv;

		// ----------------------------------------
		// centering window, eight frames
		// ----------------------------------------
		if (q.gen[TPA_GEN_CENTER] && serial_frame_in_i) begin
			d.ctr_frames = q.ctr_frames + 4'h1;
			if (q.ctr_frames == TPA_CENTER_FRAMES - 4'h1) begin
				d.gen[TPA_GEN_CENTER] = 1'b0;
				d.ctr_frames = 4'h0;
			end
		end

		// ----------------------------------------
		// block program fill
		// ----------------------------------------
		fill_edge = q.fill_rx ? ser_edge : ptx_edge;
		case (q.fill)
		TPA_FILL_IDLE: begin
		end
		TPA_FILL_WAIT: begin
			if (serial_frame_in_i) begin
				d.fill = TPA_FILL_RUN;
				d.addr = 12'h000;
			end
		end
		TPA_FILL_RUN: begin
			if (fill_edge) begin
				d.we = 1'b1;
				d.addr = q.addr + 12'h001;
				if (q.addr == (q.fill_rx ? TPA_RX_LAST : TPA_TX_LAST)) begin
					d.fill = TPA_FILL_IDLE;
					d.gen[TPA_GEN_BPE] = 1'b0;
				end
			end
		end
		default: d.fill = TPA_FILL_IDLE;
		endcase

		// ----------------------------------------
		// register port
		// ----------------------------------------
		if (bus.wr) begin
			if (bus.addr == TPA_ADDR_INTERFACE) begin
				d.intf = bus.wdata;
			end else if (bus.addr == TPA_ADDR_CONTROL) begin
				d.ctl = bus.wdata;
			end else if (bus.addr == TPA_ADDR_TIMING) begin
				d.tim = bus.wdata;
				d.tx_lock = 1'b0;
				d.rx_lock = 1'b0;
			end else if (bus.addr == TPA_ADDR_GENERAL) begin
				d.gen = bus.wdata;
				d.ctr_frames = 4'h0;
				if (bus.wdata[TPA_GEN_BPE]) begin
					d.fill = TPA_FILL_WAIT;
					d.fill_rx = q.ctl[TPA_CTL_SEL_LO +: 3] == TPA_SEL_RX_HIGH;
				end else begin
					d.fill = TPA_FILL_IDLE;
				end
			end else if (bus.addr == TPA_ADDR_ALARM) begin
				// mask taken from wdata[7:4], flags cleared
				d.alm = {bus.wdata[7:4], 4'h0};
			end
		end
		// new events win over the clearing write
		d.alm = d.alm | flags;
		d.irq = |(d.alm[3:0] & ~d.alm[7:4]);

		if (bus.rd) begin
			d.rvalid = 1'b1;
			if (bus.addr == TPA_ADDR_INTERFACE) begin
				d.rdata = q.intf;
			end else if (bus.addr == TPA_ADDR_CONTROL) begin
				d.rdata = q.ctl;
			end else if (bus.addr == TPA_ADDR_TIMING) begin
				d.rdata = q.tim;
			end else if (bus.addr == TPA_ADDR_GENERAL) begin
				d.rdata = q.gen;
			end else if (bus.addr == TPA_ADDR_ALARM) begin
				d.rdata = q.alm;
			end else begin
				d.rdata = 8'h00;
			end
		end
		// no output frames until the phase is locked
		d.ptx_frame = d.ptx_frame && tx_timed && q.tx_lock;
		d.ser_frame = d.ser_frame && q.rx_lock;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
			q.intf <= TPA_RST_INTERFACE;
			q.fill <= TPA_FILL_IDLE;
		end else begin
			q <= d;
		end
	end

	assign bus.rdata = q.rdata;
	assign bus.rvalid = q.rvalid;
	assign bus.irq = q.irq;
	assign par_tx_frame_out_o = q.ptx_frame;
	assign serial_frame_out_o = q.ser_frame;
	assign serial_clock_out_o = q.sclk_out;
	assign fill_we_o = q.we;
	assign fill_rx_o = q.fill_rx;
	assign fill_addr_o = q.addr;
	assign fill_nibble_o = q.gen[TPA_GEN_NIB_LO +: 4];
endmodule
`default_nettype wire

//--- design/tpa_host.sv
// Purpose: host sequencer: power-up setup and one block-program run.
// Assumes: device answers reads one cycle after the strobe.
// Notes:   wait count is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`default_nettype none
module tpa_host #(
	parameter int WAIT_CYCLES = tpa_pkg::TPA_WAIT_CYCLES
) (
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	tpa_if.host             bus,
	input  wire logic       start_i,
	input  wire logic       rx_sel_i,
	input  wire logic [1:0] mode_i,
	input  wire logic [3:0] nibble_i,
	output logic            busy_o,
	output logic            ok_o,
	output logic            retry_o
);
	import tpa_pkg::*;

	typedef struct packed {
		tpa_host_t  st;
		logic [1:0] step;
		logic [31:0] cnt;
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       busy;
		logic       ok;
		logic       retry;
	} tpa_hst_t;

	tpa_hst_t q, d;
	logic [7:0] mask;

	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.rd = 1'b0;
		// all alarms unmasked so the irq line follows them
		mask = 8'h00;
		case (q.st)
		TPA_H_IDLE: begin
			if (start_i) begin
				d.busy = 1'b1;
				d.ok = 1'b0;
				d.retry = 1'b0;
				d.st = TPA_H_SEL;
				d.step = 2'h0;
			end
		end
		TPA_H_SEL: begin
			// setup: timing, serial mode, alarm clear, select
			d.wr = 1'b1;
			d.step = q.step + 2'h1;
			if (q.step == 2'h0) begin
				d.addr = TPA_ADDR_TIMING;
				d.wdata = {6'h00, mode_i};
			end else if (q.step == 2'h1) begin
				d.addr = TPA_ADDR_INTERFACE;
				d.wdata = TPA_RST_INTERFACE;
			end else if (q.step == 2'h2) begin
				d.addr = TPA_ADDR_ALARM;
				d.wdata = mask;
			end else begin
				d.addr = TPA_ADDR_CONTROL;
				d.wdata = {5'h00, rx_sel_i ? TPA_SEL_RX_HIGH : TPA_SEL_TX_HIGH};
				d.st = TPA_H_GEN;
			end
		end
		TPA_H_GEN: begin
			// centering bit left low during fill
			d.wr = 1'b1;
			d.addr = TPA_ADDR_GENERAL;
			d.wdata = {nibble_i, 4'h1};
			d.cnt = 32'h0;
			d.st = TPA_H_WAIT;
		end
		TPA_H_WAIT: begin
			d.cnt = q.cnt + 32'h1;
			if (q.cnt == 32'(WAIT_CYCLES)) begin
				d.rd = 1'b1;
				d.addr = TPA_ADDR_GENERAL;
				d.st = TPA_H_CHECK;
			end
		end
		TPA_H_CHECK: begin
			if (bus.rvalid) begin
				if (bus.rdata[TPA_GEN_BPE]) begin
					// clock likely missing: force the fill off
					d.wr = 1'b1;
					d.addr = TPA_ADDR_GENERAL;
					d.wdata = 8'h00;
					d.st = TPA_H_DONE;
				end else begin
					d.rd = 1'b1;
					d.addr = TPA_ADDR_ALARM;
					d.st = TPA_H_READ;
				end
			end
		end
		TPA_H_READ: begin
			if (bus.rvalid) begin
				// flag retry if framing or path alarm rose
				d.retry = bus.rdata[TPA_ALM_FRAMING] ||
					  bus.rdata[TPA_ALM_RX] || bus.rdata[TPA_ALM_TX];
				d.ok = 1'b1;
				d.st = TPA_H_DONE;
			end
		end
		TPA_H_DONE: begin
			d.busy = 1'b0;
			d.st = TPA_H_IDLE;
		end
		default: d.st = TPA_H_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
			q.st <= TPA_H_IDLE;
		end else begin
			q <= d;
		end
	end

	assign bus.wr = q.wr;
	assign bus.rd = q.rd;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
	assign busy_o = q.busy;
	assign ok_o = q.ok;
	assign retry_o = q.retry;
endmodule
`default_nettype wire

//--- design/tpa_if.sv
// Purpose: register strobe bus between host cpu and device control.
// Assumes: single clock, one access per strobe.
// Notes:   read data valid one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
interface tpa_if;
	logic       wr;
	logic       rd;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rvalid;
	logic       irq;

	modport dev (
		input  wr, rd, addr, wdata,
		output rdata, rvalid, irq
	);
	modport host (
		output wr, rd, addr, wdata,
		input  rdata, rvalid, irq
	);
endinterface
`default_nettype wire

//--- design/tpa_pkg.sv
// Purpose: shared constants and types for the phase-align and block-program
//          control, device end and host end.
// Assumes: one 200 MHz clock; tdm clocks and frame pulses arrive as inputs
//          synchronous to it.
// Notes:   the register port is a small strobe bus carried by the interface.
//
// Overview of operation
// - tx-timed: move parallel tx frame to serial frame
// - tx lock loss: correct, set tx alarm
// - host keeps clocks stable during tx memory writes
// - host watches tx alarm, rereads address zero (host reads the alarm register once, never address zero)
// - rx-timed: invert serial clock out to align
// - rx lock loss: correct, set rx alarm
// - flag framing change at rx parallel port
// - host avoids centering during rx memory writes
// - host programs rx memory without correction risk
// - block fill upper nibble of selected memory
// - host selects memory and serial mode first
// - enable self-clears on completion; host checks later
// - host writing enable low aborts fill
// - fill advances on tdm clock and framing
// - host keeps centering off during block fill
// - host repeats fill if alarm raised meanwhile (host only sets retry_o, no repeat)
// - host programs mode registers at power-up
// - alignment runs in tx-timed, rx-timed external clocks
// - centering narrows window, self-clears after eight frames
// - host writes no memory while centering
// - centering mainly recommended for rx-timed mode
// - alarm flags in status, unmasked drive interrupt
// - any status write clears flags and interrupt, except flags raised by events in the same cycle
package tpa_pkg;

	// register indices on the strobe bus
	localparam logic [3:0] TPA_ADDR_INTERFACE = 4'h0;
	localparam logic [3:0] TPA_ADDR_CONTROL   = 4'h1;
	localparam logic [3:0] TPA_ADDR_TIMING    = 4'h2;
	localparam logic [3:0] TPA_ADDR_GENERAL   = 4'h3;
	localparam logic [3:0] TPA_ADDR_ALARM     = 4'h4;

	// reset values
	localparam logic [7:0] TPA_RST_INTERFACE = 8'h60;
	localparam logic [7:0] TPA_RST_ZERO      = 8'h00;

	// general purpose mode register fields
	localparam int TPA_GEN_BPE    = 0;
	localparam int TPA_GEN_CENTER = 1;
	localparam int TPA_GEN_NIB_LO = 4;

	// timing mode register fields
	localparam int TPA_TIM_MODE_LO = 0;
	localparam int TPA_TIM_INTERNAL_CLOCK_SELECT  = 2;
	localparam logic [1:0] TPA_MODE_TX_TIMED = 2'h0;
	localparam logic [1:0] TPA_MODE_RX_TIMED = 2'h1;

	// control register memory select values
	localparam int TPA_CTL_SEL_LO = 0;
	localparam logic [2:0] TPA_SEL_TX_HIGH = 3'h1;
	localparam logic [2:0] TPA_SEL_RX_HIGH = 3'h3;

	// alarm register: flags low nibble, masks high nibble
	localparam int TPA_ALM_FRAMING = 0;
	localparam int TPA_ALM_RX      = 1;
	localparam int TPA_ALM_TX      = 2;
	localparam int TPA_ALM_FSYNC   = 3;
	localparam int TPA_ALM_MASK_LO = 4;

	// memory sizes
	localparam int TPA_TX_DEPTH = 2430;
	localparam int TPA_RX_DEPTH = 512;
	localparam logic [11:0] TPA_TX_LAST = 12'(TPA_TX_DEPTH - 1);
	localparam logic [11:0] TPA_RX_LAST = 12'(TPA_RX_DEPTH - 1);

	// phase window, in tdm clock edges between the two frame pulses
	localparam logic [3:0] TPA_WIN_WIDE   = 4'h4;
	localparam logic [3:0] TPA_WIN_NARROW = 4'h1;
	localparam logic [3:0] TPA_CENTER_FRAMES = 4'h8;
	localparam logic [7:0] TPA_PHASE_MAX  = 8'hff;

	// host timing: 250 us wait at 5 ns per clock
	localparam int TPA_CLK_PERIOD_NS = 5;
	localparam int TPA_WAIT_US       = 250;
	localparam int TPA_WAIT_CYCLES   = TPA_WAIT_US * 1000 / TPA_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		TPA_FILL_IDLE = 2'b00,
		TPA_FILL_WAIT = 2'b01,
		TPA_FILL_RUN  = 2'b11
	} tpa_fill_t;

	typedef enum logic [2:0] {
		TPA_H_IDLE   = 3'b000,
		TPA_H_SEL    = 3'b001,
		TPA_H_GEN    = 3'b011,
		TPA_H_WAIT   = 3'b010,
		TPA_H_CHECK  = 3'b110,
		TPA_H_READ   = 3'b111,
		TPA_H_DONE   = 3'b101
	} tpa_host_t;

endpackage

//--- testbench/tpa_checker.sv
// Purpose: temporal checks on the host/device strobe bus
// Assumes: one clock, reset asynchronous and active low
// Notes:   sees interface signals only, no design internals
`timescale 1ns/1ps
`default_nettype none
module tpa_checker (
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       rvalid,
	input wire logic       irq
);
	import tpa_pkg::*;
	// ------------------------------
	// bus and alarm relations
	// ------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_rd_answer; rd |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	property p_no_stray; rvalid |-> $past(rd); endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("answer without read");
	property p_rdata_holds; !rvalid |-> $stable(rdata); endproperty
	a_rdata_holds: assert property (p_rdata_holds)
		else $error("read data moved between reads");
	property p_strobe_excl; !(wr && rd); endproperty
	a_strobe_excl: assert property (p_strobe_excl)
		else $error("read and write together");
	// bench keeps alarm events away from the clearing write
	property p_irq_clear;
		wr && addr == TPA_ADDR_ALARM |=> !irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("irq not cleared by alarm write");
	property p_irq_fall;
		$fell(irq) |-> $past(wr) && $past(addr) == TPA_ADDR_ALARM;
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("irq fell without alarm write");
	property p_host_order;
		rd && addr == TPA_ADDR_GENERAL
			|-> ##[1:4] (rd && addr == TPA_ADDR_ALARM);
	endproperty
	a_host_order: assert property (p_host_order)
		else $error("alarm not read after enable check");
	property p_bpe_wait;
		wr && addr == TPA_ADDR_GENERAL && wdata[TPA_GEN_BPE]
			|=> !rd [*8];
	endproperty
	a_bpe_wait: assert property (p_bpe_wait)
		else $error("host read during fill wait");
endmodule
`default_nettype wire

//--- testbench/tpa_phase_align_and_cm_block_program_test.sv
// Purpose: host and device joined, block fills and lock loss
// Assumes: tdm clocks at half rate, frame every 256 cycles
// Notes:   host wait shortened; fill must fit inside it
`timescale 1ns/1ps
`default_nettype none
module tpa_phase_align_and_cm_block_program_test;
	import tpa_pkg::*;
	localparam int WAIT  = 6000;
	localparam int LIMIT = 60000;
	logic        clock_i, rst_b_i, sck, ptck, sfi, prfi;
	logic        start, rx_sel, ptfo, sfo, scko, we, frx;
	logic        busy, ok, retry, inv_a, inv_b, sckp;
	logic [1:0]  mode;
	logic [3:0]  nib, fnib;
	logic [11:0] faddr;
	logic [31:0] last_addr;
	int          fails, n_checks, cyc, fcnt, soff, poff;
	int          n_fill, n_bad, n_ptx, n_sfo;
	tpa_if bus_if ();
	tpa_device tpa_device_i (
		.clock_i            (clock_i),
		.rst_b_i            (rst_b_i),
		.bus                (bus_if),
		.serial_port_clock_i(sck),
		.par_tx_clock_i     (ptck),
		.serial_frame_in_i  (sfi),
		.par_rx_frame_in_i  (prfi),
		.par_tx_frame_out_o (ptfo),
		.serial_frame_out_o (sfo),
		.serial_clock_out_o (scko),
		.fill_we_o          (we),
		.fill_rx_o          (frx),
		.fill_addr_o        (faddr),
		.fill_nibble_o      (fnib)
	);
	tpa_host #(.WAIT_CYCLES(WAIT)) tpa_host_i (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.bus     (bus_if),
		.start_i (start),
		.rx_sel_i(rx_sel),
		.mode_i  (mode),
		.nibble_i(nib),
		.busy_o  (busy),
		.ok_o    (ok),
		.retry_o (retry)
	);
	tpa_checker tpa_checker_i (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.wr     (bus_if.wr),
		.rd     (bus_if.rd),
		.addr   (bus_if.addr),
		.wdata  (bus_if.wdata),
		.rdata  (bus_if.rdata),
		.rvalid (bus_if.rvalid),
		.irq    (bus_if.irq)
	);
	// ------------------------------
	// clock, tdm timing, timeout
	// ------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		fcnt <= (fcnt + 1) % 256;
		sck  <= ~sck;
		ptck <= ~ptck;
		sfi  <= (fcnt == soff);
		prfi <= (fcnt == poff);
		cyc  <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one host run; sh 1 moves rx frame, sh 2 moves serial frame
	task automatic run(input logic [1:0] m, input logic rx,
		input logic [3:0] nv, input int sh);
		int i;
		n_fill = 0;
		n_bad = 0;
		n_ptx = 0;
		n_sfo = 0;
		@(posedge clock_i);
		mode <= m;
		rx_sel <= rx;
		nib <= nv;
		start <= 1'b1;
		@(posedge clock_i);
		start <= 1'b0;
		for (i = 0; i < 9000 && (i < 3 || busy !== 1'b0); i++) begin
			@(posedge clock_i);
			#1;
			if (we === 1'b1) begin
				n_fill++;
				last_addr = {20'h0_0000, faddr};
				if (fnib !== nv || frx !== rx)
					n_bad++;
			end
			// skip the cycles before the new timing write lands
			if (ptfo === 1'b1 && i > 20)
				n_ptx++;
			if (sfo === 1'b1 && i > 20)
				n_sfo++;
			if (i == 1500)
				inv_a = scko ^ sckp;
			if (i == 2000 && sh == 1)
				poff = 40;
			if (i == 2000 && sh == 2)
				soff = 40;
			if (i == 5000)
				inv_b = scko ^ sckp;
			sckp = sck;
		end
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_tx_fill();
		run(TPA_MODE_TX_TIMED, 1'b0, 4'hA, 0);
		check(n_fill, TPA_TX_DEPTH, "tx fill count");
		check(n_bad, 0, "tx fill data");
		check(last_addr, TPA_TX_DEPTH, "tx fill end");
		check({31'h0, ok}, 1, "tx enable not cleared");
		check({31'h0, retry}, 0, "tx spurious alarm");
		check({31'h0, n_ptx != 0}, 1, "no tx frame out");
		check(n_sfo, 0, "serial frame out in tx mode");
		check({31'h0, bus_if.irq}, 0, "tx irq raised");
		$display("done tx fill");
	endtask
	task automatic t_rx_fill();
		run(TPA_MODE_RX_TIMED, 1'b1, 4'h5, 0);
		check(n_fill, TPA_RX_DEPTH, "rx fill count");
		check(n_bad, 0, "rx fill data");
		check(last_addr, TPA_RX_DEPTH, "rx fill end");
		check({31'h0, ok}, 1, "rx enable not cleared");
		check({31'h0, retry}, 0, "rx spurious alarm");
		check(n_ptx, 0, "tx frame out in rx mode");
		check({31'h0, n_sfo != 0}, 1, "no serial frame out");
		check({31'h0, bus_if.irq}, 0, "rx irq raised");
		$display("done rx fill");
	endtask
	task automatic t_rx_alarm();
		run(TPA_MODE_RX_TIMED, 1'b1, 4'h3, 1);
		check({31'h0, retry}, 1, "rx lock loss unseen");
		check({31'h0, inv_a ^ inv_b}, 1, "clock not inverted");
		check({31'h0, bus_if.irq}, 1, "rx alarm irq low");
		$display("done rx alarm");
	endtask
	task automatic t_tx_alarm();
		run(TPA_MODE_TX_TIMED, 1'b0, 4'hC, 2);
		check({31'h0, retry}, 1, "tx lock loss unseen");
		check({31'h0, bus_if.irq}, 1, "tx alarm irq low");
		$display("done tx alarm");
	endtask
	initial begin
		rst_b_i = 1'b0;
		{start, rx_sel, sck, ptck, sfi, prfi, sckp} = 7'h00;
		mode = 2'h0;
		nib = 4'h0;
		cyc = 0;
		fcnt = 0;
		soff = 0;
		poff = 0;
		fails = 0;
		n_checks = 0;
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		t_tx_fill();
		t_rx_fill();
		t_rx_alarm();
		t_tx_alarm();
		conclude();
	end
endmodule
`default_nettype wire
